// >>> inc/swdi_dog_if.sv
// Control and expiry signals between the block and its watchdog counter
`timescale 1ns/1ps
interface swdi_dog_if;
  logic run;
  logic clear;
  logic use_pre;
  logic [2:0] ratio;
  logic expire;
  modport ctl (output run, output clear, output use_pre, output ratio, input expire);
  modport dog (input run, input clear, input use_pre, input ratio, output expire);
endinterface : swdi_dog_if

// >>> inc/swdi_pkg.sv
// Constants for the sleep, wake, watchdog and interrupt block
// Summary of operation
// - Timer wrap from ff to 00 sets overflow flag bit 2; enable bit 5.
// - Edge pin counts rising edges when option bit 6 is one, else falling.
// - Qualifying edge sets control bit 1; enable bit 4 gates the request.
// - Edge wake needs its enable set before sleep; global enable picks vectoring.
// - Level change on any of three pins sets bit 0; enable bit 3.
// - Interrupt entry saves only the return program counter.
// - Watchdog keeps its own time base and runs during sleep.
// - Expiry while running resets the device; while asleep it wakes it.
// - Fuse word bit 3 cleared disables the watchdog for good.
// - Base period 18 ms; prescaler assignment stretches it up to 1:128.
// - Kick or sleep clears the watchdog and its assigned prescaler.
// - Watchdog expiry clears the active-low time-out status bit.
// - Sleep clears watchdog, clears power-down bit, sets time-out bit, stops oscillator.
// - Pins hold their driven state throughout sleep.
// - External reset in sleep resets; expiry or enabled interrupt just wakes.
// - Only converter completion on its own clock wakes from peripherals.
// - Interrupt wake needs the source enable, regardless of global enable.
// - After wake the prefetched instruction runs, then vector if global enabled.
// - Enabled flag set before sleep with globals off makes sleep a no-op.
// - Flag rising during or after sleep: sleep completes, then wakes at once.
// - Flags set on their events whatever the enables.
// - Taking an interrupt clears global enable, pushes return address, loads vector.
package swdi_pkg;
  localparam int ADDR_W = 16;
  localparam int PC_W = 13;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_TIMER = 16'h0001;
  localparam logic [15:0] IDX_STATUS = 16'h0003;
  localparam logic [15:0] IDX_IRQ_CTL = 16'h000b;
  localparam logic [15:0] IDX_AUX = 16'h000c;
  localparam logic [15:0] IDX_OPTION = 16'h0081;
  localparam logic [15:0] IDX_FUSE = 16'h2007;
  // Interrupt control fields
  localparam int B_GIE = 7;
  localparam int B_TIMER_OVERFLOW_ENABLE = 5;
  localparam int B_EDGE_IRQ_ENABLE = 4;
  localparam int B_PIN_CHANGE_ENABLE = 3;
  localparam int B_TIMER_OVERFLOW_FLAG = 2;
  localparam int B_EDGE_IRQ_FLAG = 1;
  localparam int B_PIN_CHANGE_FLAG = 0;
  // Option fields
  localparam int B_EDGE_POL = 6;
  localparam int B_PSA = 3;
  localparam int B_PS_LSB = 0;
  // Status fields
  localparam int B_TO_N = 4;
  localparam int B_PD_N = 3;
  // Aux fields
  localparam int B_ADF = 0;
  localparam int B_ADE = 1;
  // Fuse fields
  localparam int B_DOG_FUSE = 3;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] IRQ_CTL_RST = 8'h00;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  // Watchdog time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DOG_PERIOD_MS = 18;
  localparam int unsigned DOG_PERIOD_CYC = DOG_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DOG_CNT_W = 24;
  typedef enum logic {SWDI_RUN, SWDI_SLEEP} swdi_state_e;
endpackage : swdi_pkg

// >>> logic/swdi_dog.sv
// Watchdog counter with its own time base and optional prescaler
`timescale 1ns/1ps
module swdi_dog import swdi_pkg::*; #(
  parameter int unsigned DOG_CYC = DOG_PERIOD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  swdi_dog_if.dog dog
);
  logic [DOG_CNT_W-1:0] base_q;
  logic [6:0] pre_q;
  logic base_end;
  logic pre_end;

  // Counts on pclk whatever the sleep state, standing in for a free RC source
  assign base_end = (base_q == DOG_CNT_W'(DOG_CYC - 1));
  assign pre_end = !dog.use_pre || (pre_q == 7'((8'h01 << dog.ratio) - 8'h01));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= '0;
      pre_q <= '0;
      dog.expire <= 1'b0;
    end else if (!dog.run) begin
      base_q <= '0;
      pre_q <= '0;
      dog.expire <= 1'b0;
    end else if (dog.clear) begin
      base_q <= '0;
      pre_q <= '0;
      dog.expire <= 1'b0;
    end else begin
      dog.expire <= base_end && pre_end;
      if (base_end) begin
        base_q <= '0;
        pre_q <= pre_end ? 7'h00 : pre_q + 7'h01;
      end else begin
        base_q <= base_q + DOG_CNT_W'(1);
      end
    end
  end
endmodule : swdi_dog

// >>> logic/swdi_top.sv
// Sleep control, watchdog supervision and interrupt flags behind an APB slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module swdi_top import swdi_pkg::*; #(
  parameter int unsigned DOG_CYC = DOG_PERIOD_CYC,
  parameter int GPIO_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_tick,
  input wire logic instr_done,
  input wire logic op_sleep,
  input wire logic op_kick,
  input wire logic [PC_W-1:0] ret_pc,
  input wire logic ad_done,
  input wire logic ad_rc_clock,
  input wire logic edge_irq_pin,
  input wire logic change_pin_a,
  input wire logic change_pin_b,
  input wire logic change_pin_c,
  input wire logic ext_reset_pin_n,
  input wire logic [7:0] config_fuse,
  input wire logic [GPIO_W-1:0] gpio_out_d,
  input wire logic [GPIO_W-1:0] gpio_oe_d,
  output logic [GPIO_W-1:0] gpio_out,
  output logic [GPIO_W-1:0] gpio_oe,
  output logic asleep,
  output logic osc_drive_en,
  output logic wake,
  output logic dog_reset,
  output logic irq_pending,
  output logic stack_push,
  output logic [PC_W-1:0] stack_pc,
  output logic vector_load,
  output logic [PC_W-1:0] vector_pc
);
  localparam int NPIN = 5;

  swdi_dog_if dog_if ();

  swdi_state_e state_q;
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [7:0] option_q;
  logic [7:0] timer_q;
  logic [7:0] tpre_q;
  logic [7:0] fuse_q;
  logic fuse_caught_q;
  logic to_n_q;
  logic pd_n_q;
  logic adf_q;
  logic ade_q;
  logic [3:0] wake_en_q;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] prev_q;
  logic [1:0] warm_q;
  logic warm;
  logic ext_rst;
  logic edge_ev;
  logic chg_ev;
  logic ad_ev;
  logic t0_ovf;
  logic timer_inc;
  logic [3:0] flags;
  logic [3:0] enables;
  logic pending;
  logic running;
  logic sleep_nop;
  logic sleep_go;
  logic dog_exp;
  logic dog_rst;
  logic dev_rst;
  logic wake_now;
  logic take_irq;
  logic setup;
  logic wr;
  logic [15:0] idx;
  logic hit;
  logic [7:0] rdata;

  // Pin synchronisers, one two-stage chain per pin
  assign pin_raw = {ext_reset_pin_n, change_pin_c, change_pin_b, change_pin_a, edge_irq_pin};
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_q[i] <= 1'b1;
        sync2_q[i] <= 1'b1;
        prev_q[i] <= 1'b1;
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
        prev_q[i] <= sync2_q[i];
      end
    end
  end

  // Pins may rest at either level, so edges count only once the chain holds real samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_q <= 2'b00;
    end else if (warm_q != 2'b11) begin
      warm_q <= warm_q + 2'b01;
    end
  end
  assign warm = (warm_q == 2'b11);

  assign running = (state_q == SWDI_RUN);
  assign ext_rst = !sync2_q[NPIN-1];
  // Edge detect compares the synchronised sample with the one before
  assign edge_ev = warm && (option_q[B_EDGE_POL] ? (sync2_q[0] && !prev_q[0]) : (!sync2_q[0] && prev_q[0]));
  assign chg_ev = warm && (|(sync2_q[3:1] ^ prev_q[3:1]));
  // Converter completion only counts in sleep when it runs from its own clock
  assign ad_ev = ad_done && (running || ad_rc_clock);

  // APB decode: index is the byte address divided by four
  assign setup = psel && !penable;
  // A refused transfer carries pslverr with pready and must not write
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign idx = {2'b00, paddr[ADDR_W-1:2]};
  always_comb begin
    hit = 1'b1;
    rdata = 8'h00;
    case (idx)
      IDX_TIMER: rdata = timer_q;
      IDX_STATUS: rdata = (8'(to_n_q) << B_TO_N) | (8'(pd_n_q) << B_PD_N);
      IDX_IRQ_CTL: rdata = ctl_q;
      IDX_AUX: rdata = (8'(ade_q) << B_ADE) | (8'(adf_q) << B_ADF);
      IDX_OPTION: rdata = option_q;
      IDX_FUSE: rdata = fuse_q;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && (!hit || paddr[1:0] != 2'b00);
      if (setup) begin
        prdata <= {24'h00_0000, rdata};
      end
    end
  end

  // Fuse word is a strap, caught once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_q <= 8'h00;
      fuse_caught_q <= 1'b0;
    end else if (!fuse_caught_q) begin
      fuse_q <= config_fuse;
      fuse_caught_q <= 1'b1;
    end
  end

  // Watchdog control
  assign dog_if.run = fuse_caught_q && fuse_q[B_DOG_FUSE];
  assign dog_if.use_pre = option_q[B_PSA];
  assign dog_if.ratio = option_q[B_PS_LSB +: 3];
  assign dog_if.clear = op_kick || sleep_go || dev_rst;
  assign dog_exp = dog_if.expire;
  assign dog_rst = dog_exp && running;
  assign dev_rst = ext_rst || dog_rst;

  swdi_dog #(.DOG_CYC(DOG_CYC)) u_dog (
    .pclk(pclk),
    .presetn(presetn),
    .dog(dog_if)
  );

  // Interrupt sources, ordered timer, edge, change, converter
  assign flags = {ctl_q[B_TIMER_OVERFLOW_FLAG], ctl_q[B_EDGE_IRQ_FLAG], ctl_q[B_PIN_CHANGE_FLAG], adf_q};
  assign enables = {ctl_q[B_TIMER_OVERFLOW_ENABLE], ctl_q[B_EDGE_IRQ_ENABLE], ctl_q[B_PIN_CHANGE_ENABLE], ade_q};
  assign pending = |(flags & enables);
  assign sleep_nop = !ctl_q[B_GIE] && pending;
  assign sleep_go = op_sleep && running && !sleep_nop;
  // Enables latched at sleep entry decide which flags may wake
  assign wake_now = !running && (dog_exp || |(flags & wake_en_q));
  // Taken at an instruction boundary, so the prefetched one runs first after wake
  assign take_irq = running && instr_done && ctl_q[B_GIE] && pending;

  // Free timer and its share of the prescaler, frozen while the core clock is off
  assign timer_inc = running && timer_tick
    && (option_q[B_PSA] || tpre_q == 8'((9'h002 << option_q[B_PS_LSB +: 3]) - 9'h001));
  assign t0_ovf = timer_inc && (timer_q == 8'hff) && !(wr && idx == IDX_TIMER);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= 8'h00;
      tpre_q <= 8'h00;
    end else if (dev_rst) begin
      timer_q <= 8'h00;
      tpre_q <= 8'h00;
    end else begin
      // A software write to the timer wins over a pending increment
      if (wr && idx == IDX_TIMER) begin
        timer_q <= pwdata[7:0];
        tpre_q <= 8'h00;
      end else if (timer_inc) begin
        timer_q <= timer_q + 8'h01;
        tpre_q <= 8'h00;
      end else if (running && timer_tick && !option_q[B_PSA]) begin
        tpre_q <= tpre_q + 8'h01;
      end
    end
  end

  // Flags: a write stores, events then OR in, so a set beats a clear
  always_comb begin
    ctl_d = ctl_q;
    if (wr && idx == IDX_IRQ_CTL) begin
      ctl_d = pwdata[7:0];
    end
    if (take_irq) begin
      ctl_d[B_GIE] = 1'b0;
    end
    ctl_d[B_TIMER_OVERFLOW_FLAG] = ctl_d[B_TIMER_OVERFLOW_FLAG] | t0_ovf;
    ctl_d[B_EDGE_IRQ_FLAG] = ctl_d[B_EDGE_IRQ_FLAG] | edge_ev;
    ctl_d[B_PIN_CHANGE_FLAG] = ctl_d[B_PIN_CHANGE_FLAG] | chg_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= IRQ_CTL_RST;
      option_q <= OPTION_RST;
      adf_q <= 1'b0;
      ade_q <= 1'b0;
    end else if (dev_rst) begin
      ctl_q <= IRQ_CTL_RST;
      option_q <= OPTION_RST;
      adf_q <= 1'b0;
      ade_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      if (wr && idx == IDX_OPTION) begin
        option_q <= pwdata[7:0];
      end
      if (wr && idx == IDX_AUX) begin
        ade_q <= pwdata[B_ADE];
        adf_q <= pwdata[B_ADF] | ad_ev;
      end else begin
        adf_q <= adf_q | ad_ev;
      end
    end
  end

  // Status bits; a true power-up leaves both set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
    end else if (dog_exp && dog_if.run) begin
      to_n_q <= 1'b0;
      if (running) begin
        pd_n_q <= 1'b1;
      end
    end else if (sleep_go) begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b0;
    end else if (op_kick && running) begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
    end
  end

  // Sleep sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SWDI_RUN;
      wake_en_q <= 4'h0;
    end else if (dev_rst) begin
      state_q <= SWDI_RUN;
      wake_en_q <= 4'h0;
    end else begin
      case (state_q)
        SWDI_RUN: begin
          if (sleep_go) begin
            state_q <= SWDI_SLEEP;
            // Timer flag cannot rise in sleep, so its enable is left out
            wake_en_q <= {1'b0, enables[2:0]};
          end
        end
        SWDI_SLEEP: begin
          if (wake_now) begin
            state_q <= SWDI_RUN;
          end
        end
        default: state_q <= SWDI_RUN;
      endcase
    end
  end

  // Registered outputs
  // Asleep follows the next state, except that a sleep meeting a device reset still sets it for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asleep <= 1'b0;
      osc_drive_en <= 1'b1;
      wake <= 1'b0;
      dog_reset <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      asleep <= sleep_go || (!running && !wake_now && !dev_rst);
      osc_drive_en <= !(sleep_go || (!running && !wake_now && !dev_rst));
      wake <= wake_now && !dev_rst;
      dog_reset <= dev_rst;
      irq_pending <= pending && ctl_q[B_GIE];
    end
  end

  // Only the return address is handed to the stack on entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_push <= 1'b0;
      stack_pc <= '0;
      vector_load <= 1'b0;
      vector_pc <= '0;
    end else begin
      stack_push <= take_irq && !dev_rst;
      vector_load <= take_irq && !dev_rst;
      if (take_irq) begin
        stack_pc <= ret_pc;
        vector_pc <= IRQ_VECTOR;
      end
    end
  end

  // Pins freeze at their pre-sleep drive and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out <= '0;
      gpio_oe <= '0;
    end else if (running && !sleep_go) begin
      gpio_out <= gpio_out_d;
      gpio_oe <= gpio_oe_d;
    end
  end
endmodule : swdi_top

// >>> tb/sleep_wake_watchdog_irq_tb.sv
// Self-checking bench for the sleep, wake, watchdog and interrupt block
`timescale 1ns/1ps
module sleep_wake_watchdog_irq_tb import swdi_pkg::*;;
  // Short watchdog count keeps expiry tests within a few hundred cycles
  localparam int DOG_N = 40;
  localparam int SLP = 0, KICK = 1, TICK = 2, DONE = 3, ADC = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic timer_tick, instr_done, op_sleep, op_kick, ad_done, ad_rc_clock;
  logic edge_irq_pin, ext_reset_pin_n, asleep, osc_drive_en, wake, dog_reset;
  logic irq_pending, stack_push, vector_load;
  logic [2:0] chg;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] config_fuse, rd;
  logic [PC_W-1:0] ret_pc, stack_pc, vector_pc;
  logic [5:0] gpio_out_d, gpio_oe_d, gpio_out, gpio_oe;
  wire logic [2:0] evt;
  int n_fail = 0, num_checks = 0, n_rst = 0, cyc = 0;
  assign evt = {vector_load, dog_reset, wake};
  swdi_top #(.DOG_CYC(DOG_N)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_tick, .instr_done, .op_sleep, .op_kick, .ret_pc, .ad_done, .ad_rc_clock,
    .edge_irq_pin, .change_pin_a(chg[0]), .change_pin_b(chg[1]), .change_pin_c(chg[2]), .ext_reset_pin_n,
    .config_fuse, .gpio_out_d, .gpio_oe_d, .gpio_out, .gpio_oe, .asleep, .osc_drive_en, .wake, .dog_reset,
    .irq_pending, .stack_push, .stack_pc, .vector_load, .vector_pc);
  swdi_pins pins_u (.pclk, .edge_irq_pin, .chg, .ext_reset_pin_n);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (dog_reset === 1'b1) n_rst++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic e;
    apb(1'b1, idx, d, e);
  endtask : wr
  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input logic [7:0] m);
    logic e;
    apb(1'b0, idx, 8'h00, e);
    check(rd & m, exp);
  endtask : rdc
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      SLP: op_sleep <= 1'b1;
      KICK: op_kick <= 1'b1;
      TICK: timer_tick <= 1'b1;
      DONE: instr_done <= 1'b1;
      default: ad_done <= 1'b1;
    endcase
    @(posedge pclk);
    {op_sleep, op_kick, timer_tick, instr_done, ad_done} <= 5'h00;
  endtask : pulse
  task automatic wait_hi(input int k, output int n);
    n = 0;
    while (evt[k] !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      n_fail++;
      $display("unexpected at %0t: event %0d never came", $time, k);
    end
  endtask : wait_hi
  task automatic do_reset(input logic [7:0] f);
    @(posedge pclk);
    presetn <= 1'b0;
    config_fuse <= f;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  task automatic t_regs;
    logic e;
    rdc(IDX_OPTION, OPTION_RST, 8'hff);
    apb(1'b0, 16'h0002, 8'h00, e);
    check({7'h00, e}, 8'h01);
    wr(IDX_FUSE, 8'hff);
    rdc(IDX_FUSE, 8'h00, 8'hff);
    wr(IDX_OPTION, 8'h48);
    rdc(IDX_OPTION, 8'h48, 8'hff);
    $display("registers done");
  endtask : t_regs
  task automatic t_flags;
    wr(IDX_TIMER, 8'hff);
    pulse(TICK);
    repeat (3) @(posedge pclk);
    rdc(IDX_IRQ_CTL, 8'h04, 8'hff);
    pins_u.set_edge(1'b1);
    repeat (6) @(posedge pclk);
    rdc(IDX_IRQ_CTL, 8'h06, 8'hff);
    wr(IDX_IRQ_CTL, 8'h00);
    wr(IDX_OPTION, 8'h08);
    pins_u.set_edge(1'b0);
    repeat (6) @(posedge pclk);
    rdc(IDX_IRQ_CTL, 8'h02, 8'hff);
    wr(IDX_IRQ_CTL, 8'h00);
    pins_u.set_edge(1'b1);
    repeat (6) @(posedge pclk);
    rdc(IDX_IRQ_CTL, 8'h00, 8'hff);
    for (int i = 0; i < 3; i++) begin
      pins_u.flip_pin(i);
      repeat (6) @(posedge pclk);
      rdc(IDX_IRQ_CTL, 8'h01, 8'hff);
      wr(IDX_IRQ_CTL, 8'h89);
      repeat (2) @(posedge pclk);
      check({7'h00, irq_pending}, 8'h01);
      wr(IDX_IRQ_CTL, 8'h81);
      repeat (2) @(posedge pclk);
      check({7'h00, irq_pending}, 8'h00);
      wr(IDX_IRQ_CTL, 8'h00);
    end
    $display("flags done");
  endtask : t_flags
  task automatic t_take;
    int n;
    wr(IDX_IRQ_CTL, 8'h90);
    pins_u.set_edge(1'b0);
    ret_pc <= 13'h0456;
    repeat (6) @(posedge pclk);
    pulse(DONE);
    wait_hi(2, n);
    check({4'h0, vector_load, stack_push, vector_pc === 13'h0004, stack_pc === 13'h0456}, 8'h0f);
    rdc(IDX_IRQ_CTL, 8'h12, 8'hff);
    wr(IDX_IRQ_CTL, 8'h10);
    wr(IDX_IRQ_CTL, 8'h90);
    repeat (2) @(posedge pclk);
    check({7'h00, irq_pending}, 8'h00);
    $display("interrupt entry done");
  endtask : t_take
  task automatic t_sleep;
    int n;
    wr(IDX_IRQ_CTL, 8'h10);
    gpio_out_d <= 6'h15;
    gpio_oe_d <= 6'h3f;
    pins_u.set_edge(1'b1);
    repeat (6) @(posedge pclk);
    pulse(SLP);
    repeat (2) @(posedge pclk);
    check({6'h00, asleep, osc_drive_en}, 8'h02);
    gpio_out_d <= 6'h2a;
    gpio_oe_d <= 6'h0c;
    rdc(IDX_STATUS, 8'h10, 8'h18);
    check({2'h0, gpio_out}, 8'h15);
    check({2'h0, gpio_oe}, 8'h3f);
    pins_u.set_edge(1'b0);
    wait_hi(0, n);
    check({7'h00, wake}, 8'h01);
    repeat (2) @(posedge pclk);
    check({2'h0, gpio_out}, 8'h2a);
    check({2'h0, gpio_oe}, 8'h0c);
    wr(IDX_IRQ_CTL, 8'h00);
    wr(IDX_AUX, 8'h02);
    pulse(SLP);
    repeat (3) @(posedge pclk);
    pulse(ADC);
    repeat (4) @(posedge pclk);
    check({7'h00, asleep}, 8'h01);
    ad_rc_clock <= 1'b1;
    pulse(ADC);
    wait_hi(0, n);
    check({7'h00, wake}, 8'h01);
    ad_rc_clock <= 1'b0;
    pulse(KICK);
    pulse(SLP);
    repeat (3) @(posedge pclk);
    check({7'h00, asleep}, 8'h00);
    rdc(IDX_STATUS, 8'h18, 8'h18);
    $display("sleep done");
  endtask : t_sleep
  task automatic t_dog;
    int n;
    int m;
    for (int r = 0; r < 2; r++) begin
      pulse(KICK);
      wr(IDX_OPTION, 8'h48 | 8'(r));
      pulse(KICK);
      wait_hi(1, n);
      check({7'h00, n >= (DOG_N << r) - 2 && n <= (DOG_N << r) + 6}, 8'h01);
    end
    rdc(IDX_OPTION, OPTION_RST, 8'hff);
    rdc(IDX_STATUS, 8'h08, 8'h18);
    pulse(KICK);
    wr(IDX_OPTION, 8'h48);
    m = n_rst;
    pulse(SLP);
    wait_hi(0, n);
    check({6'h00, wake, n_rst == m}, 8'h03);
    rdc(IDX_STATUS, 8'h00, 8'h18);
    pulse(KICK);
    pulse(SLP);
    m = n_rst;
    pins_u.pulse_reset(6);
    repeat (3) @(posedge pclk);
    check({6'h00, asleep, n_rst > m}, 8'h01);
    rdc(IDX_OPTION, OPTION_RST, 8'hff);
    $display("watchdog done");
  endtask : t_dog
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = 32'h00000000;
    {timer_tick, instr_done, op_sleep, op_kick, ad_done, ad_rc_clock} = 6'h00;
    ret_pc = 13'h0123;
    gpio_out_d = 6'h00;
    gpio_oe_d = 6'h00;
    config_fuse = 8'h00;
    do_reset(8'h00);
    t_regs();
    t_flags();
    t_take();
    t_sleep();
    check({7'h00, n_rst == 0}, 8'h01);
    do_reset(8'h08);
    t_dog();
    end_of_test();
  end
endmodule : sleep_wake_watchdog_irq_tb

// >>> tb/swdi_assertions.sv
// Port-level checker for the sleep, wake, watchdog and interrupt block
`timescale 1ns/1ps
module swdi_checker import swdi_pkg::*; #(
  parameter int GPIO_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [PC_W-1:0] ret_pc,
  input wire logic ext_reset_pin_n,
  input wire logic [7:0] config_fuse,
  input wire logic [GPIO_W-1:0] gpio_out,
  input wire logic [GPIO_W-1:0] gpio_oe,
  input wire logic asleep,
  input wire logic osc_drive_en,
  input wire logic wake,
  input wire logic dog_reset,
  input wire logic irq_pending,
  input wire logic stack_push,
  input wire logic [PC_W-1:0] stack_pc,
  input wire logic vector_load,
  input wire logic [PC_W-1:0] vector_pc
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_osc_off_asleep: assert property (osc_drive_en == !asleep)
    else $error("oscillator driver does not follow sleep");
  a_wake_ends_sleep: assert property (wake |=> !asleep && !wake)
    else $error("wake did not end sleep in one pulse");
  a_pins_held_sleep: assert property (asleep && $past(asleep) |-> $stable(gpio_out) && $stable(gpio_oe))
    else $error("pins moved during sleep");
  a_vector_to_handler: assert property (vector_load |-> stack_push && vector_pc == IRQ_VECTOR)
    else $error("bad vector load");
  a_push_return_pc: assert property (stack_push |-> stack_pc == $past(ret_pc))
    else $error("pushed pc is not the return pc");
  a_take_drops_pending: assert property (vector_load |-> ##[1:2] !irq_pending)
    else $error("global enable kept after take");
  a_pin_reset_holds: assert property (!ext_reset_pin_n [*5] |-> dog_reset)
    else $error("reset pin low without device reset");
  a_dog_fuse_off: assert property ((!config_fuse[B_DOG_FUSE] && ext_reset_pin_n) [*5] |-> !dog_reset)
    else $error("device reset with watchdog fused off");
endmodule : swdi_checker

bind swdi_top swdi_checker #(.GPIO_W(GPIO_W)) chk_u (.pclk, .presetn, .psel, .penable, .pready, .ret_pc,
  .ext_reset_pin_n, .config_fuse, .gpio_out, .gpio_oe, .asleep, .osc_drive_en, .wake, .dog_reset,
  .irq_pending, .stack_push, .stack_pc, .vector_load, .vector_pc);

// >>> tb/swdi_pins.sv
// Model of the edge, pin-change and reset pin sources
`timescale 1ns/1ps
module swdi_pins (
  input wire logic pclk,
  output logic edge_irq_pin,
  output logic [2:0] chg,
  output logic ext_reset_pin_n
);
  // Reset pin rests high, as a pulled-up line would
  initial begin
    edge_irq_pin = 1'b0;
    chg = 3'h0;
    ext_reset_pin_n = 1'b1;
  end
  task automatic set_edge(input logic v);
    @(posedge pclk);
    edge_irq_pin <= v;
  endtask : set_edge
  task automatic flip_pin(input int i);
    @(posedge pclk);
    chg[i] <= ~chg[i];
  endtask : flip_pin
  task automatic pulse_reset(input int c);
    @(posedge pclk);
    ext_reset_pin_n <= 1'b0;
    repeat (c) @(posedge pclk);
    ext_reset_pin_n <= 1'b1;
  endtask : pulse_reset
endmodule : swdi_pins
